/* rtl/dwis_defines.vh */
`ifndef DWIS_DEFINES_VH
`define DWIS_DEFINES_VH

// clock and spike suppression timing
`define DWIS_CLK_PERIOD_NS 5
`define DWIS_SPIKE_NS 50
`define DWIS_SPIKE_CYC (`DWIS_SPIKE_NS / `DWIS_CLK_PERIOD_NS)
`define DWIS_FILT_W 4

// address layout
`define DWIS_ADDR_PREFIX 4'h5
`define DWIS_PREFIX_HI 7
`define DWIS_PREFIX_LO 4
`define DWIS_STRAP_HI 3
`define DWIS_STRAP_LO 1
`define DWIS_DIR_BIT 0

// command byte values
`define DWIS_CMD_A 8'h11
`define DWIS_CMD_B 8'h12
`define DWIS_CMD_AB 8'h13

// position codes
`define DWIS_CODE_W 8
`define DWIS_CODE_MID 8'h80
`define DWIS_CODE_ZERO 8'h00

// bit counting
`define DWIS_CNT_W 4
`define DWIS_CNT_ZERO 4'h0
`define DWIS_CNT_ONE 4'h1
`define DWIS_CNT_ACK 4'h8

// transfer states
`define DWIS_ST_W 3
`define DWIS_ST_IDLE 3'h0
`define DWIS_ST_ADDR 3'h1
`define DWIS_ST_CMD 3'h2
`define DWIS_ST_DATA 3'h3
`define DWIS_ST_SKIP 3'h4
`define DWIS_ST_IGNORE 3'h5

`endif

/* rtl/dwis_sync.v */
`timescale 1ns/10ps
`default_nettype none

module dwis_sync #(
   parameter WIDTH = 1
) (
   // clock and reset
   input wire clk,
   input wire resetn,
   // asynchronous levels in, synchronised levels out
   input wire [WIDTH-1:0] asyncIn,
   output reg [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1_r;

   // stage1_r feeds only the second flop
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stage1_r <= {WIDTH{1'b1}};
         syncOut <= {WIDTH{1'b1}};
      end else begin
         stage1_r <= asyncIn;
         syncOut <= stage1_r;
      end
   end

endmodule

`default_nettype wire

/* rtl/dwis_slave.v */
// Behaviour
// - each channel holds an 8-bit code selecting one of 256 taps
// - channels keep separate codes; writing one leaves the other alone
// - a written code reaches the wiper output at once, no commit step
// - both codes come up at midscale after reset
// - shift bits in, decode address and command, route data byte
// - both lines rest high when idle; device releases data line
// - data falling while clock high is a start condition
// - data rising while clock high is a stop; return to idle
// - one bit per clock pulse, data stable while clock is high
// - device pulls data low through the acknowledge pulse high phase
// - eighth address bit low writes; high is a no-operation transfer
// - no read path: device never returns register contents
// - address must be prefix 0101 then the three strap levels, high first
// - command 11h writes A, 12h writes B, 13h writes both
// - code 00h is lowest tap, FFh is highest tap
`timescale 1ns/10ps
`default_nettype none
`include "dwis_defines.vh"

module dwis_slave #(
   parameter CODE_W = `DWIS_CODE_W,
   parameter SPIKE_CYC = `DWIS_SPIKE_CYC
) (
   // clock and reset
   input wire clk,
   input wire resetn,
   // serial bus pins
   input wire sclIn,
   input wire sdaIn,
   output reg sdaOut,
   output reg sdaOe,
   // address straps
   input wire strap_bit_zero,
   input wire strap_bit_one,
   input wire strap_bit_two,
   // wiper position codes
   output reg [CODE_W-1:0] wiperOutA,
   output reg [CODE_W-1:0] wiperOutB,
   // status
   output reg busBusy,
   output reg addrMatched,
   output reg updateA,
   output reg updateB
);

   localparam integer FILT_LAST_I = SPIKE_CYC - 1;
   localparam [`DWIS_FILT_W-1:0] FILT_LAST = FILT_LAST_I[`DWIS_FILT_W-1:0];
   localparam [`DWIS_ST_W-1:0] ST_IDLE = `DWIS_ST_IDLE;
   localparam [`DWIS_ST_W-1:0] ST_ADDR = `DWIS_ST_ADDR;
   localparam [`DWIS_ST_W-1:0] ST_CMD = `DWIS_ST_CMD;
   localparam [`DWIS_ST_W-1:0] ST_DATA = `DWIS_ST_DATA;
   localparam [`DWIS_ST_W-1:0] ST_SKIP = `DWIS_ST_SKIP;
   localparam [`DWIS_ST_W-1:0] ST_IGNORE = `DWIS_ST_IGNORE;

   wire sclSync;
   wire sdaSync;
   wire [2:0] strapSync;

   reg sclFilt_r;
   reg sdaFilt_r;
   reg [`DWIS_FILT_W-1:0] sclCnt_r;
   reg [`DWIS_FILT_W-1:0] sdaCnt_r;
   reg sclPrev_r;
   reg sdaPrev_r;

   reg [`DWIS_ST_W-1:0] state_r;
   reg [`DWIS_ST_W-1:0] state_nxt;
   reg [`DWIS_CNT_W-1:0] bitCnt_r;
   reg [7:0] shift_r;
   reg [7:0] cmd_r;
   reg ackPhase_r;

   wire sclRise;
   wire sclFall;
   wire startSeen;
   wire stopSeen;
   wire addrHit;
   wire byteDone;
   wire cmdKnown;

   // bus pins and straps come from outside the clock domain
   dwis_sync #(
      .WIDTH(2)
   ) u_pinSync (
      .clk(clk),
      .resetn(resetn),
      .asyncIn({sclIn, sdaIn}),
      .syncOut({sclSync, sdaSync})
   );

   dwis_sync #(
      .WIDTH(3)
   ) u_strapSync (
      .clk(clk),
      .resetn(resetn),
      .asyncIn({strap_bit_two, strap_bit_one, strap_bit_zero}),
      .syncOut(strapSync)
   );

   // a level must hold for the spike time before it is believed
   function [`DWIS_FILT_W-1:0] filtCount;
      input sample;
      input held;
      input [`DWIS_FILT_W-1:0] cnt;
      begin
         if (sample == held) begin
            filtCount = {`DWIS_FILT_W{1'b0}};
         end else if (cnt == FILT_LAST) begin
            filtCount = {`DWIS_FILT_W{1'b0}};
         end else begin
            filtCount = cnt + {{(`DWIS_FILT_W-1){1'b0}}, 1'b1};
         end
      end
   endfunction

   function filtLevel;
      input sample;
      input held;
      input [`DWIS_FILT_W-1:0] cnt;
      begin
         if (sample != held && cnt == FILT_LAST) begin
            filtLevel = sample;
         end else begin
            filtLevel = held;
         end
      end
   endfunction

   // same delay on both lines keeps their order, so zero data hold is safe
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sclFilt_r <= 1'b1;
         sdaFilt_r <= 1'b1;
         sclCnt_r <= {`DWIS_FILT_W{1'b0}};
         sdaCnt_r <= {`DWIS_FILT_W{1'b0}};
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end else begin
         sclFilt_r <= filtLevel(sclSync, sclFilt_r, sclCnt_r);
         sdaFilt_r <= filtLevel(sdaSync, sdaFilt_r, sdaCnt_r);
         sclCnt_r <= filtCount(sclSync, sclFilt_r, sclCnt_r);
         sdaCnt_r <= filtCount(sdaSync, sdaFilt_r, sdaCnt_r);
         sclPrev_r <= sclFilt_r;
         sdaPrev_r <= sdaFilt_r;
      end
   end

   assign sclRise = sclFilt_r & ~sclPrev_r;
   assign sclFall = ~sclFilt_r & sclPrev_r;
   assign startSeen = sclFilt_r & sclPrev_r & sdaPrev_r & ~sdaFilt_r;
   assign stopSeen = sclFilt_r & sclPrev_r & ~sdaPrev_r & sdaFilt_r;

   // prefix then straps, highest strap first
   assign addrHit = (shift_r[`DWIS_PREFIX_HI:`DWIS_PREFIX_LO] == `DWIS_ADDR_PREFIX) &&
                    (shift_r[`DWIS_STRAP_HI:`DWIS_STRAP_LO] == strapSync);

   // eighth rising edge done, byte ends at the following falling edge
   assign byteDone = sclFall && !ackPhase_r && (bitCnt_r == `DWIS_CNT_ACK);

   assign cmdKnown = (cmd_r == `DWIS_CMD_A) || (cmd_r == `DWIS_CMD_B) ||
                     (cmd_r == `DWIS_CMD_AB);

   // byte-level sequencing
   always @* begin
      state_nxt = state_r;
      if (byteDone) begin
         case (state_r)
            ST_ADDR: begin
               if (!addrHit) begin
                  state_nxt = ST_IGNORE;
               end else if (shift_r[`DWIS_DIR_BIT]) begin
                  state_nxt = ST_SKIP;
               end else begin
                  state_nxt = ST_CMD;
               end
            end
            ST_CMD: begin
               state_nxt = ST_DATA;
            end
            ST_DATA: begin
               state_nxt = ST_SKIP;
            end
            ST_SKIP: begin
               state_nxt = ST_SKIP;
            end
            ST_IGNORE: begin
               state_nxt = ST_IGNORE;
            end
            ST_IDLE: begin
               state_nxt = ST_IDLE;
            end
            default: begin
               state_nxt = ST_IDLE;
            end
         endcase
      end
   end

   // start wins over everything, including a repeated start mid-byte
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
      end else if (startSeen) begin
         state_r <= ST_ADDR;
      end else if (stopSeen) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // bit shifter and acknowledge slot tracking
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bitCnt_r <= `DWIS_CNT_ZERO;
         shift_r <= 8'h00;
         ackPhase_r <= 1'b0;
      end else if (startSeen || stopSeen) begin
         bitCnt_r <= `DWIS_CNT_ZERO;
         ackPhase_r <= 1'b0;
      end else if (state_r == ST_IDLE || state_r == ST_IGNORE) begin
         bitCnt_r <= `DWIS_CNT_ZERO;
         ackPhase_r <= 1'b0;
      end else if (sclRise && !ackPhase_r && bitCnt_r != `DWIS_CNT_ACK) begin
         shift_r <= {shift_r[6:0], sdaFilt_r};
         bitCnt_r <= bitCnt_r + `DWIS_CNT_ONE;
      end else if (byteDone) begin
         ackPhase_r <= 1'b1;
      end else if (sclFall && ackPhase_r) begin
         ackPhase_r <= 1'b0;
         bitCnt_r <= `DWIS_CNT_ZERO;
      end
   end

   // data line: only ever pulled low in an acknowledge slot
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sdaOut <= 1'b0;
         sdaOe <= 1'b0;
      end else if (startSeen || stopSeen) begin
         sdaOe <= 1'b0;
      end else if (byteDone) begin
         // no acknowledge for a foreign address; never drive read data
         sdaOe <= (state_r != ST_ADDR) || addrHit;
      end else if (sclFall && ackPhase_r) begin
         sdaOe <= 1'b0;
      end
   end

   // command capture and wiper registers
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cmd_r <= 8'h00;
         wiperOutA <= `DWIS_CODE_MID;
         wiperOutB <= `DWIS_CODE_MID;
         updateA <= 1'b0;
         updateB <= 1'b0;
      end else begin
         updateA <= 1'b0;
         updateB <= 1'b0;
         if (byteDone && state_r == ST_CMD) begin
            cmd_r <= shift_r;
         end
         // written only once all eight data bits are in; a stop before that writes nothing
         if (byteDone && state_r == ST_DATA && cmdKnown) begin
            if (cmd_r == `DWIS_CMD_A || cmd_r == `DWIS_CMD_AB) begin
               wiperOutA <= shift_r;
               updateA <= 1'b1;
            end
            if (cmd_r == `DWIS_CMD_B || cmd_r == `DWIS_CMD_AB) begin
               wiperOutB <= shift_r;
               updateB <= 1'b1;
            end
         end
      end
   end

   // status for the surrounding logic; the clock line is input only
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         busBusy <= 1'b0;
         addrMatched <= 1'b0;
      end else begin
         if (startSeen) begin
            busBusy <= 1'b1;
         end else if (stopSeen) begin
            busBusy <= 1'b0;
         end
         if (startSeen || stopSeen) begin
            addrMatched <= 1'b0;
         end else if (byteDone && state_r == ST_ADDR) begin
            addrMatched <= addrHit;
         end
      end
   end

endmodule

`default_nettype wire

/* testbench/dwis_slave_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module dwis_slave_props #(
   parameter CODE_W = 8,
   parameter SPIKE_CYC = 10
) (
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // bus pins
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   // straps
   input wire logic strap_bit_zero,
   input wire logic strap_bit_one,
   input wire logic strap_bit_two,
   // codes and status
   input wire logic [CODE_W-1:0] wiperOutA,
   input wire logic [CODE_W-1:0] wiperOutB,
   input wire logic busBusy,
   input wire logic addrMatched,
   input wire logic updateA,
   input wire logic updateB
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence ackRise;
      $rose(sdaOe);
   endsequence
   // ack must hold for at least eight cycles, then let go within 30 more
   sequence ackHeld;
      sdaOe [*8] ##[1:30] !sdaOe;
   endsequence
   AST_RESET_MID: assert property ($rose(resetn) |-> wiperOutA == 8'h80 && wiperOutB == 8'h80)
      else $error("codes not midscale after reset");
   AST_A_ONLY_ON_UPDATE: assert property (!$stable(wiperOutA) |-> updateA)
      else $error("code A moved without update");
   AST_B_ONLY_ON_UPDATE: assert property (!$stable(wiperOutB) |-> updateB)
      else $error("code B moved without update");
   AST_UPDATE_PULSE: assert property (updateA || updateB |=> !updateA && !updateB)
      else $error("update longer than one cycle");
   AST_UPDATE_WITH_ACK: assert property (updateA || updateB |-> $rose(sdaOe) && busBusy && addrMatched)
      else $error("code written outside an acked transfer");
   AST_DRIVE_LOW: assert property (sdaOe |-> !sdaOut)
      else $error("data driven high");
   AST_IDLE_RELEASED: assert property (!busBusy |-> !sdaOe)
      else $error("data pulled while idle");
   AST_STABLE_SCL_HIGH: assert property (sclIn && $past(sclIn) |-> $stable(sdaOe))
      else $error("data drive moved while clock high");
   AST_ACK_HOLD: assert property (ackRise |-> ackHeld)
      else $error("ack not held through its pulse");
   AST_START_SEEN: assert property ($fell(sdaIn) && sclIn |-> ##[1:20] busBusy)
      else $error("start not recognised");
   AST_STOP_SEEN: assert property ($rose(sdaIn) && sclIn |-> ##[1:20] !busBusy)
      else $error("stop not recognised");
endmodule
bind dwis_slave dwis_slave_props #(.CODE_W(CODE_W), .SPIKE_CYC(SPIKE_CYC)) dwis_slave_props_inst (
   .clk(clk), .resetn(resetn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
   .strap_bit_zero(strap_bit_zero), .strap_bit_one(strap_bit_one), .strap_bit_two(strap_bit_two),
   .wiperOutA(wiperOutA), .wiperOutB(wiperOutB), .busBusy(busBusy), .addrMatched(addrMatched),
   .updateA(updateA), .updateB(updateB));
`default_nettype wire

/* testbench/dwis_bus_master.sv */
`timescale 1ns/10ps
`default_nettype none
module dwis_bus_master (
   // clock
   input wire logic clk,
   // bus lines
   output logic sclOut,
   output logic sdaDrv,
   input wire logic sdaWire
);
   initial begin
      sclOut = 1'b1;
      sdaDrv = 1'b1;
   end
   task automatic waitClk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // also serves as repeated start right after an ack slot
   task automatic busStart;
      waitClk(8);
      sdaDrv <= 1'b1;
      waitClk(5);
      sclOut <= 1'b1;
      waitClk(12);
      sdaDrv <= 1'b0;
      waitClk(12);
      sclOut <= 1'b0;
   endtask
   task automatic busStop;
      waitClk(8);
      sdaDrv <= 1'b0;
      waitClk(5);
      sclOut <= 1'b1;
      waitClk(12);
      sdaDrv <= 1'b1;
      waitClk(12);
   endtask
   // 25 clocks a pulse gives the 125 ns bus period
   task automatic busByte(input logic [7:0] b, output logic ack);
      logic [8:0] bits;
      bits = {b, 1'b1};
      for (int i = 8; i >= 0; i--) begin
         waitClk(8);
         sdaDrv <= bits[i];
         waitClk(5);
         sclOut <= 1'b1;
         waitClk(6);
         ack = (sdaWire === 1'b0);
         waitClk(6);
         sclOut <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk, resetn, strap0, strap1, strap2, sclM, sdaM, sdaOut, sdaOe;
   logic busBusy, addrMatched, updateA, updateB;
   logic [7:0] wiperOutA, wiperOutB;
   wire sdaWire;
   int nMismatch = 0;
   int numChecks = 0;
   logic [7:0] nUpdA = 8'h00;
   logic [7:0] nUpdB = 8'h00;
   // open drain: pull-up unless someone pulls low
   assign sdaWire = sdaOe ? sdaOut : sdaM;
   dwis_slave #(.CODE_W(8), .SPIKE_CYC(2)) dwis_slave_inst (.clk(clk), .resetn(resetn), .sclIn(sclM),
      .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .strap_bit_zero(strap0), .strap_bit_one(strap1),
      .strap_bit_two(strap2), .wiperOutA(wiperOutA), .wiperOutB(wiperOutB), .busBusy(busBusy),
      .addrMatched(addrMatched), .updateA(updateA), .updateB(updateB));
   dwis_bus_master dwis_bus_master_inst (.clk(clk), .sclOut(sclM), .sdaDrv(sdaM), .sdaWire(sdaWire));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // update pulses stand one cycle, so they are counted as they pass
   always @(posedge clk) begin
      if (updateA === 1'b1) begin
         nUpdA <= nUpdA + 8'h01;
      end
      if (updateB === 1'b1) begin
         nUpdB <= nUpdB + 8'h01;
      end
   end
   task automatic chkBit(input logic got, input logic exp, input string msg);
      numChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic chkCode(input logic [7:0] got, input logic [7:0] exp, input string msg);
      numChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("CHECK FAILED at %0t: %s got %h", $time, msg, got);
      end
   endtask
   task automatic testDone;
      $display("checks %0d mismatches %0d", numChecks, nMismatch);
      if (nMismatch == 0 && numChecks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic sendByte(input logic [7:0] b, input logic expAck);
      logic ack;
      dwis_bus_master_inst.busByte(b, ack);
      chkBit(ack, expAck, "ack slot");
   endtask
   task automatic wr(input logic [7:0] adr, input logic [7:0] cmd, input logic [7:0] dat,
      input logic expAck, input logic [7:0] expA, input logic [7:0] expB, input string name);
      dwis_bus_master_inst.busStart();
      sendByte(adr, expAck);
      chkBit(addrMatched, expAck, "address match flag");
      sendByte(cmd, expAck);
      sendByte(dat, expAck);
      dwis_bus_master_inst.busStop();
      chkCode(wiperOutA, expA, "code A");
      chkCode(wiperOutB, expB, "code B");
      chkBit(busBusy, 1'b0, "busy after stop");
      $display("test %s done", name);
   endtask
   initial begin
      resetn = 1'b0;
      strap0 = 1'b0;
      strap1 = 1'b0;
      strap2 = 1'b0;
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      repeat (14) @(posedge clk);
      chkCode(wiperOutA, 8'h80, "reset A");
      chkCode(wiperOutB, 8'h80, "reset B");
      $display("test reset done");
      wr(8'h50, 8'h11, 8'h00, 1'b1, 8'h00, 8'h80, "write A low");
      wr(8'h50, 8'h12, 8'hff, 1'b1, 8'h00, 8'hff, "write B high");
      wr(8'h50, 8'h13, 8'h5a, 1'b1, 8'h5a, 8'h5a, "write both");
      wr(8'h50, 8'h88, 8'h33, 1'b1, 8'h5a, 8'h5a, "unknown command");
      wr(8'h51, 8'h11, 8'h33, 1'b1, 8'h5a, 8'h5a, "no-operation");
      strap0 <= 1'b1;
      strap2 <= 1'b1;
      wr(8'h50, 8'h11, 8'h33, 1'b0, 8'h5a, 8'h5a, "old straps");
      wr(8'hda, 8'h11, 8'h33, 1'b0, 8'h5a, 8'h5a, "wrong prefix");
      wr(8'h5a, 8'h12, 8'h96, 1'b1, 8'h5a, 8'h96, "strap address");
      // partial transfer cut by a repeated start, then one cut by a stop
      dwis_bus_master_inst.busStart();
      sendByte(8'h5a, 1'b1);
      sendByte(8'h11, 1'b1);
      wr(8'h5a, 8'h11, 8'h3c, 1'b1, 8'h3c, 8'h96, "repeated start");
      dwis_bus_master_inst.busStart();
      sendByte(8'h5a, 1'b1);
      sendByte(8'h12, 1'b1);
      dwis_bus_master_inst.busStop();
      chkCode(wiperOutB, 8'h96, "stop mid transfer");
      chkCode(wiperOutA, 8'h3c, "stop mid transfer A");
      $display("test stop mid transfer done");
      chkCode(nUpdA, 8'h03, "update A pulses");
      chkCode(nUpdB, 8'h03, "update B pulses");
      $display("test update pulses done");
      testDone();
   end
   initial begin
      repeat (60000) @(posedge clk);
      nMismatch++;
      testDone();
   end
endmodule
`default_nettype wire
